//--- src/dac_map.svh
// register map constants for the stereo dac control register bank
`ifndef DAC_MAP_SVH
`define DAC_MAP_SVH

// word layout
`define DAC_DIR_BIT 15
`define DAC_IDX_HI 14
`define DAC_IDX_LO 8
`define DAC_DIR_WRITE 1'h0
`define DAC_DIR_READ 1'h1

// register indices
`define DAC_IDX_OVS 7'h12
`define DAC_IDX_OUT 7'h13
`define DAC_IDX_FMT 7'h14

// index 18 field used here
`define DAC_OVS_BIT 6

// index 19 fields
`define DAC_LEFT_DIS_BIT 0
`define DAC_RIGHT_DIS_BIT 1
`define DAC_DEEMPH_EN_BIT 4
`define DAC_DEEMPH_RATE_HI 6
`define DAC_DEEMPH_RATE_LO 5

// index 20 fields
`define DAC_FMT_HI 2
`define DAC_FMT_LO 0
`define DAC_CLK_DIS_BIT 3
`define DAC_CLK_DIV_BIT 4
`define DAC_ROLLOFF_HI 6
`define DAC_ROLLOFF_LO 5
`define DAC_INTERP_BIT 7

// reset values
`define DAC_RST_1 1'h0
`define DAC_RST_2 2'h0
`define DAC_RST_3 3'h0
`define DAC_RST_16 16'h0000

`endif

//--- src/dac_pkg.sv
// types for the stereo dac control register bank
package dac_pkg;

    typedef enum logic [1:0] {
        DAC_DEEMPH_44K1,
        DAC_DEEMPH_48K,
        DAC_DEEMPH_32K,
        DAC_DEEMPH_RSVD
    } dac_deemph_rate_t;

    typedef enum logic [2:0] {
        DAC_FMT_RJ24,
        DAC_FMT_RJ20,
        DAC_FMT_RJ18,
        DAC_FMT_RJ16,
        DAC_FMT_I2S,
        DAC_FMT_RJ_ANY,
        DAC_FMT_RSVD6,
        DAC_FMT_RSVD7
    } dac_fmt_t;

    // register bus request
    typedef struct packed {
        logic [15:0] word;
        logic wr;
        logic rd;
    } dac_bus_req_t;

    // decoded settings presented to the audio path
    typedef struct packed {
        logic ovs_128x;
        logic left_output_disable;
        logic right_output_disable;
        logic deemph_enable;
        dac_deemph_rate_t deemph_rate_select;
        dac_fmt_t audio_format_select;
        logic clock_out_disable;
        logic clock_out_divide;
        logic [1:0] filter_rolloff_select;
        logic interp_rate_select;
    } dac_cfg_t;

endpackage

//--- src/dac_out_sel.sv
// per channel output select between audio sample and bipolar zero
`timescale 1ns/10ps
`default_nettype none
module dac_out_sel #(
    parameter int W = 24
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control
    input wire logic disable_out,
    // data
    input wire logic signed [W-1:0] sample_in,
    output logic signed [W-1:0] sample_out
);
    typedef struct packed {
        logic signed [W-1:0] q;
    } dac_os_state_t;

    dac_os_state_t st_r;
    dac_os_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.q = disable_out ? '0 : sample_in;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sample_out = st_r.q;
endmodule
`default_nettype wire

//--- src/dac_ctrl_regs.sv
// control register bank of the stereo audio dac
`timescale 1ns/10ps
`include "dac_map.svh"
`default_nettype none

// Operation
// - oversampling bit: 0 gives 64x, 1 gives 128x, resets cleared
// - word bit 15: 0 writes, 1 reads; defaults to write
// - bit 0 of index 19 is left, bit 1 right, independent
// - output bit 0 passes audio, 1 holds bipolar zero
// - index 19 bit 4 enables de-emphasis, resets cleared
// - de-emphasis rate 00 44.1k, 01 48k, 10 32k, 11 reserved
// - index 20 format field selects justified, I2S or 16-24 bit modes
// - interpolation bit: 0 gives 8x, 1 gives 4x
module dac_ctrl_regs
    import dac_pkg::*;
#(
    parameter int SAMPLE_W = 24
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // audio samples in
    input wire logic signed [SAMPLE_W-1:0] left_sample_in,
    input wire logic signed [SAMPLE_W-1:0] right_sample_in,
    // audio samples to analog stage
    output logic signed [SAMPLE_W-1:0] left_analog_output,
    output logic signed [SAMPLE_W-1:0] right_analog_output,
    // settings
    output dac_pkg::dac_cfg_t cfg
);
    import dac_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        dac_cfg_t cfg;
        logic [15:0] rdata;
    } dac_state_t;

    dac_state_t st_r;
    dac_state_t st_nxt;
    logic [6:0] idx;
    logic is_read;
    logic wr_take;
    logic left_dis;
    logic right_dis;

    // ---------------------------------------------------------------
    // readback image of one register
    // ---------------------------------------------------------------
    function automatic logic [15:0] dac_image(input logic [6:0] i, input dac_cfg_t c);
        logic [15:0] v;
        v = `DAC_RST_16;
        v[`DAC_IDX_HI:`DAC_IDX_LO] = i;
        unique case (i)
            `DAC_IDX_OVS: v[`DAC_OVS_BIT] = c.ovs_128x;
            `DAC_IDX_OUT: begin
                v[`DAC_LEFT_DIS_BIT] = c.left_output_disable;
                v[`DAC_RIGHT_DIS_BIT] = c.right_output_disable;
                v[`DAC_DEEMPH_EN_BIT] = c.deemph_enable;
                v[`DAC_DEEMPH_RATE_HI:`DAC_DEEMPH_RATE_LO] = c.deemph_rate_select;
            end
            `DAC_IDX_FMT: begin
                v[`DAC_FMT_HI:`DAC_FMT_LO] = c.audio_format_select;
                v[`DAC_CLK_DIS_BIT] = c.clock_out_disable;
                v[`DAC_CLK_DIV_BIT] = c.clock_out_divide;
                v[`DAC_ROLLOFF_HI:`DAC_ROLLOFF_LO] = c.filter_rolloff_select;
                v[`DAC_INTERP_BIT] = c.interp_rate_select;
            end
            default: v = `DAC_RST_16;
        endcase
        return v;
    endfunction

    // ---------------------------------------------------------------
    // per register write merges
    // ---------------------------------------------------------------
    // oversampling select lives alone in index 18
    function automatic dac_cfg_t dac_merge_ovs(
        input logic [15:0] w,
        input dac_cfg_t c
    );
        dac_cfg_t n;
        n = c;
        n.ovs_128x = w[`DAC_OVS_BIT];
        return n;
    endfunction

    // channel bits and de-emphasis share index 19
    function automatic dac_cfg_t dac_merge_out(
        input logic [15:0] w,
        input dac_cfg_t c
    );
        dac_cfg_t n;
        n = c;
        n.left_output_disable = w[`DAC_LEFT_DIS_BIT];
        n.right_output_disable = w[`DAC_RIGHT_DIS_BIT];
        n.deemph_enable = w[`DAC_DEEMPH_EN_BIT];
        // reserved rate code kept so readback matches the write
        n.deemph_rate_select = dac_deemph_rate_t'(w[`DAC_DEEMPH_RATE_HI:`DAC_DEEMPH_RATE_LO]);
        return n;
    endfunction

    // format, clock out and roll-off fields of index 20
    function automatic dac_cfg_t dac_merge_fmt(
        input logic [15:0] w,
        input dac_cfg_t c
    );
        dac_cfg_t n;
        n = c;
        n.audio_format_select = dac_fmt_t'(w[`DAC_FMT_HI:`DAC_FMT_LO]);
        n.clock_out_disable = w[`DAC_CLK_DIS_BIT];
        n.clock_out_divide = w[`DAC_CLK_DIV_BIT];
        n.filter_rolloff_select = w[`DAC_ROLLOFF_HI:`DAC_ROLLOFF_LO];
        n.interp_rate_select = w[`DAC_INTERP_BIT];
        return n;
    endfunction

    // true for the three indices this bank owns
    function automatic logic dac_is_mapped(input logic [6:0] i);
        return i == `DAC_IDX_OVS || i == `DAC_IDX_OUT || i == `DAC_IDX_FMT;
    endfunction

    // ---------------------------------------------------------------
    // decode and update
    // ---------------------------------------------------------------
    // register number field
    assign idx = reg_wdata[`DAC_IDX_HI:`DAC_IDX_LO];
    assign is_read = reg_wdata[`DAC_DIR_BIT] == `DAC_DIR_READ;
    // a read-flagged word on the write strobe is dropped
    assign wr_take = reg_wr && !is_read && dac_is_mapped(idx);

    always_comb begin
        st_nxt = st_r;
        if (wr_take) begin
            unique case (idx)
                `DAC_IDX_OVS: begin
                    st_nxt.cfg = dac_merge_ovs(reg_wdata, st_r.cfg);
                end
                `DAC_IDX_OUT: begin
                    st_nxt.cfg = dac_merge_out(reg_wdata, st_r.cfg);
                end
                `DAC_IDX_FMT: begin
                    st_nxt.cfg = dac_merge_fmt(reg_wdata, st_r.cfg);
                end
                default: st_nxt.cfg = st_r.cfg;
            endcase
        end
        // reads answer one cycle later; unmapped indices read zero
        st_nxt.rdata = `DAC_RST_16;
        if (reg_rd) begin
            st_nxt.rdata = dac_image(idx, st_r.cfg);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ---------------------------------------------------------------
    // settings outputs
    // ---------------------------------------------------------------
    assign reg_rdata = st_r.rdata;
    assign cfg = st_r.cfg;

    // ---------------------------------------------------------------
    // channel controls
    // ---------------------------------------------------------------
    // each channel reads only its own bit
    assign left_dis = st_r.cfg.left_output_disable;
    assign right_dis = st_r.cfg.right_output_disable;

    // ---------------------------------------------------------------
    // left channel
    // ---------------------------------------------------------------
    // bipolar zero is sample value 0; the analog stage adds the bias
    // left and right forced to zero independently
    dac_out_sel #(.W(SAMPLE_W)) u_left (
        .clk(clk),
        .sys_rst(sys_rst),
        .disable_out(left_dis),
        .sample_in(left_sample_in),
        .sample_out(left_analog_output)
    );

    // ---------------------------------------------------------------
    // right channel
    // ---------------------------------------------------------------
    // right held at zero by its own bit
    dac_out_sel #(.W(SAMPLE_W)) u_right (
        .clk(clk),
        .sys_rst(sys_rst),
        .disable_out(right_dis),
        .sample_in(right_sample_in),
        .sample_out(right_analog_output)
    );
endmodule
`default_nettype wire

//--- tb/dac_ctrl_regs_assertions.sv
// port checks for the dac control register bank
`timescale 1ns/10ps
`default_nettype none
module dac_regs_chk
    import dac_pkg::*;
#(
    parameter int SAMPLE_W = 24
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // audio and settings
    input wire logic signed [SAMPLE_W-1:0] left_sample_in,
    input wire logic signed [SAMPLE_W-1:0] right_sample_in,
    input wire logic signed [SAMPLE_W-1:0] left_analog_output,
    input wire logic signed [SAMPLE_W-1:0] right_analog_output,
    input wire dac_pkg::dac_cfg_t cfg
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic wr = reg_wr && !reg_wdata[15];
    wire logic [6:0] ix = reg_wdata[14:8];
    wire logic [7:0] d = reg_wdata[7:0];
    wire logic mapped = ix == 7'h12 || ix == 7'h13 || ix == 7'h14;

    ovs_write_a: assert property (wr && ix == 7'h12 |=> cfg.ovs_128x == $past(d[6]))
        else $error("oversampling bit not taken");
    dir_flag_a: assert property (reg_wr && reg_wdata[15] |=> $stable(cfg))
        else $error("read flagged word changed settings");
    chan_bits_a: assert property (wr && ix == 7'h13 |=>
        {cfg.right_output_disable, cfg.left_output_disable} == $past(d[1:0]))
        else $error("channel bits not taken");
    left_zero_a: assert property (cfg.left_output_disable && $past(cfg.left_output_disable)
        |-> left_analog_output == '0) else $error("left not at zero");
    right_pass_a: assert property (!cfg.right_output_disable && !$past(sys_rst)
        && !$past(cfg.right_output_disable) |-> right_analog_output == $past(right_sample_in))
        else $error("right sample not passed");
    deemph_a: assert property (wr && ix == 7'h13 |=>
        {cfg.deemph_rate_select, cfg.deemph_enable} == $past(d[6:4])) else $error("deemphasis");
    format_a: assert property (wr && ix == 7'h14 |=>
        {cfg.interp_rate_select, cfg.audio_format_select} == {$past(d[7]), $past(d[2:0])})
        else $error("format or interpolation");
    other_index_a: assert property (wr && !mapped |=> $stable(cfg))
        else $error("foreign index changed settings");
endmodule
bind dac_ctrl_regs dac_regs_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (.clk, .sys_rst, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .left_sample_in, .right_sample_in, .left_analog_output,
    .right_analog_output, .cfg);
`default_nettype wire

//--- tb/dac_host.sv
// host model issuing control words on the register port
`timescale 1ns/10ps
`default_nettype none
module dac_host (
    // clock
    input wire logic clk,
    // register port
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata
);
    initial {reg_wdata, reg_wr, reg_rd} = 18'h00000;
    // one word per strobe, flag and index from the caller
    task automatic xfer(input logic rd, input logic [15:0] w, output logic [15:0] q);
        reg_wdata <= w;
        reg_wr <= !rd;
        reg_rd <= rd;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        // idle word changes so the bank cannot lean on a stale value
        reg_wdata <= ~w;
        @(posedge clk);
        q = reg_rdata;
    endtask
    // 128x only at or below 96kHz
    function automatic logic [15:0] ovs_word(input int khz);
        return {1'b0, 7'h12, 1'b0, khz <= 96, 6'h00};
    endfunction
endmodule
`default_nettype wire

//--- tb/dac_ctrl_regs_bench.sv
// self-checking bench for the dac control register bank
`timescale 1ns/10ps
`default_nettype none
module dac_ctrl_regs_bench;
    import dac_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] lfsr = 16'h7177;
    logic [15:0] q;
    logic signed [23:0] ls = 24'h000000;
    logic signed [23:0] rs = 24'h000000;
    wire logic [15:0] wd;
    wire logic wr;
    wire logic rd;
    wire logic [15:0] rdat;
    wire logic signed [23:0] lo;
    wire logic signed [23:0] ro;
    wire dac_cfg_t cfg;
    int n_mismatch = 0;
    int check_count = 0;

    always #10 clk = ~clk;
    dac_host u_host (.clk(clk), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat));
    dac_ctrl_regs #(.SAMPLE_W(24)) u_dut (.clk(clk), .sys_rst(sys_rst), .reg_wdata(wd),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .left_sample_in(ls), .right_sample_in(rs),
        .left_analog_output(lo), .right_analog_output(ro), .cfg(cfg));

    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // readback keeps only the fields laid out for the named register
    function automatic logic [15:0] image(input logic [6:0] idx, input logic [7:0] d);
        case (idx)
            7'h12: return {1'b0, idx, d & 8'h40};
            7'h13: return {1'b0, idx, d & 8'h73};
            7'h14: return {1'b0, idx, d};
            default: return 16'h0000;
        endcase
    endfunction
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rw(input logic [6:0] idx, input logic [7:0] d);
        u_host.xfer(1'b0, {1'b0, idx, d}, q);
        chk("idle rdata", 24'h000000, 24'(q));
        u_host.xfer(1'b1, {1'b1, idx, 8'h00}, q);
        chk("readback", 24'(image(idx, d)), 24'(q));
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int i = 18; i <= 20; i++) begin
            u_host.xfer(1'b1, {1'b1, 7'(i), 8'h00}, q);
            chk("reset image", {8'h00, 1'b0, 7'(i), 8'h00}, 24'(q));
        end
        for (int i = 0; i < 8; i++) begin
            rw(7'h14, {5'h00, 3'(i)});
            rw(7'h13, {1'b0, 2'(i), 5'h10});
        end
        u_host.xfer(1'b0, u_host.ovs_word(48), q);
        u_host.xfer(1'b1, 16'h9200, q);
        chk("oversampling", 24'h001240, 24'(q));
        u_host.xfer(1'b0, 16'h94FF, q);
        u_host.xfer(1'b1, 16'h9400, q);
        chk("flagged write", 24'h001407, 24'(q));
        $display("test fields done");
        for (int i = 0; i < 40; i++) begin
            lfsr = next_rand(lfsr);
            rw(7'h12 + 7'(lfsr[9:8]), lfsr[7:0]);
        end
        $display("test random done");
        for (int m = 0; m < 4; m++) begin
            rw(7'h13, {6'h00, 2'(m)});
            for (int k = 0; k < 4; k++) begin
                lfsr = next_rand(lfsr);
                ls <= {lfsr, 8'hA5};
                rs <= {8'h5A, ~lfsr};
                @(posedge clk);
                @(negedge clk);
                chk("left out", m[0] ? 24'h000000 : ls, lo);
                chk("right out", m[1] ? 24'h000000 : rs, ro);
                @(posedge clk);
            end
        end
        $display("test audio done");
        end_sim();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
endmodule
`default_nettype wire
